// >>> shared/io_regs_pkg.sv
package io_regs_pkg;
    // register addresses in internal i/o space
    localparam logic [7:0] CLOCK_MOD_ZERO_ADDR  = 8'h0A;
    localparam logic [7:0] CLOCK_MOD_ONE_ADDR   = 8'h0B;
    localparam logic [7:0] BANK_ZERO_CTRL_ADDR  = 8'h14;
    localparam logic [7:0] MEM_TIMING_ADDR      = 8'h19;
    localparam logic [7:0] PROC_IDENTITY_ADDR   = 8'h2E;
    localparam logic [7:0] REV_IDENTITY_ADDR    = 8'h2F;
    localparam logic [7:0] PORT_A_MARKED_ADDR   = 8'hC2;
    localparam logic [7:0] PORT_B_MARKED_ADDR   = 8'hD2;
    localparam logic [7:0] PORT_C_MARKED_ADDR   = 8'hE2;
    localparam logic [7:0] PORT_D_MARKED_ADDR   = 8'hF2;
    // reset values
    localparam logic [7:0] CLOCK_MOD_RESET      = 8'h00;
    localparam logic [7:0] BANK_ZERO_RESET      = 8'h08;
    localparam logic [7:0] MEM_TIMING_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ        = 8'h00;
    // identity register fields
    localparam int         FETCH_IGNORE_BIT     = 7;
    localparam int         BOOT_MODE_HI_BIT     = 6;
    localparam int         BOOT_MODE_LO_BIT     = 5;
    localparam int         ID_CODE_HI_BIT       = 4;
    localparam int         ID_CODE_WIDTH        = 5;
    // serial timing
    localparam int         CLOCK_HZ             = 20000000;
    localparam int         BAUD_HZ              = 115200;
    localparam int         BIT_CYCLES_DEFAULT   = CLOCK_HZ / BAUD_HZ;
    localparam int         FRAME_BITS           = 11;
    localparam int         NUM_PORTS            = 4;
    localparam int         BUFFER_DEPTH         = 2;
    localparam logic       MARKER_BIT           = 1'b1;
    localparam logic       STOP_BIT             = 1'b1;
    localparam logic       START_BIT            = 1'b0;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_type;
endpackage

// >>> sim/frame_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module frame_receiver #(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic        clock,
    input  wire logic        line,
    output logic             got,
    output logic [10:0]      frame
);
    // samples each bit near its middle; frame[0] start .. frame[10] last stop
    initial begin
        got   = 1'b0;
        frame = '0;
        forever begin
            @(negedge clock);
            if (line === 1'b0) begin
                repeat (BIT_CYCLES / 2) @(negedge clock);
                for (int i = 0; i < 11; i++) begin
                    frame[i] = line;
                    if (i < 10) repeat (BIT_CYCLES) @(negedge clock);
                end
                @(posedge clock);
                got <= 1'b1;
                @(posedge clock);
                got <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import io_regs_pkg::*;
    localparam int         BITS   = 4;
    localparam logic [4:0] CPU_ID = 5'h0C; // arbitrary value
    localparam logic [4:0] REV_ID = 5'h07; // arbitrary value
    logic             clock = 1'b0;
    logic             rst   = 1'b1;
    logic [7:0]       io_addr, io_wdata, io_rdata, cm0, cm1, bank0, timing;
    logic             io_wr, io_rd, io_rvalid, fetch;
    logic [1:0]       boot;
    logic [3:0]       ready, tx_line;
    logic [3:0][7:0]  rx_buf;
    wire logic [3:0]  got;
    wire logic [10:0] frame [4];
    logic [7:0]       rd_q[$];
    logic [10:0]      tx_q[4][$];
    logic [7:0]       wo_addr [4] = '{CLOCK_MOD_ZERO_ADDR, CLOCK_MOD_ONE_ADDR, BANK_ZERO_CTRL_ADDR, MEM_TIMING_ADDR};
    logic [7:0]       mk_addr [4] = '{PORT_A_MARKED_ADDR, PORT_B_MARKED_ADDR, PORT_C_MARKED_ADDR, PORT_D_MARKED_ADDR};
    logic [7:0]       wo_out [4];
    logic [31:0]      seed = 32'hE447;
    int               fails = 0;
    int               checks_done = 0;

    assign wo_out = '{cm0, cm1, bank0, timing};
    always #25 clock = ~clock;

    revision_io_regs #(.BIT_CYCLES(BITS), .CPU_CODE(CPU_ID), .REV_CODE(REV_ID)) dut (
        .clock(clock), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .port_write_ready(ready), .boot_mode_pins(boot),
        .fetch_ignore_pin(fetch), .rx_buffer(rx_buf), .tx_line(tx_line), .clock_modulator_zero(cm0),
        .clock_modulator_one(cm1), .memory_bank_zero_control(bank0), .memory_timing_control(timing));

    for (genvar p = 0; p < 4; p++) begin : g_rx
        frame_receiver #(.BIT_CYCLES(BITS)) rx (.clock(clock), .line(tx_line[p]), .got(got[p]), .frame(frame[p]));
    end

    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clock);
        io_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        io_addr = a;
        io_rd   = 1'b1;
        rd_q.push_back(exp);
        @(negedge clock);
        io_rd = 1'b0;
        @(negedge clock);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (tx_q[0].size() + tx_q[1].size() + tx_q[2].size() + tx_q[3].size() != 0) begin
            @(negedge clock);
            n++;
            if (n > 3000) begin
                fails++;
                summarize();
            end
        end
        repeat (4) @(negedge clock);
        chk("tx_idle", 4'hF, tx_line);
    endtask

    // result watcher: oldest note against each answer
    always @(negedge clock) begin
        if (io_rvalid === 1'b1) chk("read_data", rd_q.size() ? rd_q.pop_front() : 11'h7FF, io_rdata);
        for (int p = 0; p < 4; p++) begin
            if (got[p] === 1'b1) chk("frame", tx_q[p].size() ? tx_q[p].pop_front() : 11'h7FF, frame[p]);
        end
    end

    initial begin
        io_addr  = 8'h00;
        io_wdata = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        boot     = 2'h0;
        fetch    = 1'b0;
        rx_buf   = '0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        chk("reset_mod0", 8'h00, cm0);
        chk("reset_mod1", 8'h00, cm1);
        chk("reset_bank0", 8'h08, bank0);
        chk("reset_timing", 4'h0, timing[3:0]);
        chk("reset_ready", 4'hF, ready);
        chk("reset_line", 4'hF, tx_line);
        for (int k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            wr(wo_addr[k], seed[7:0]);
            chk("write_only_reg", seed[7:0], wo_out[k]);
            rd(wo_addr[k], 8'h00);
        end
        rd(8'h33, 8'h00);
        for (int k = 0; k < 8; k++) begin
            boot  = k[1:0];
            fetch = k[2];
            repeat (3) @(negedge clock);
            wr(PROC_IDENTITY_ADDR, 8'hFF);
            rd(PROC_IDENTITY_ADDR, {fetch, boot, CPU_ID});
            rd(REV_IDENTITY_ADDR, {fetch, boot, REV_ID});
        end
        for (int k = 0; k < 4; k++) begin
            seed      = xorshift(seed);
            rx_buf[k] = seed[15:8];
            rd(mk_addr[k], seed[15:8]);
            tx_q[k].push_back({2'b11, seed[7:0], 1'b0});
            wr(mk_addr[k], seed[7:0]);
        end
        drain();
        for (int k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            if (k == 3) chk("ready_full", 1'b0, ready[0]);
            else tx_q[0].push_back({2'b11, seed[7:0], 1'b0});
            io_addr  = PORT_A_MARKED_ADDR;
            io_wdata = seed[7:0];
            io_wr    = 1'b1;
            @(negedge clock);
        end
        io_wr = 1'b0;
        drain();
        chk("reads_answered", 0, rd_q.size());
        summarize();
    end
endmodule
`default_nettype wire

// >>> verilog/revision_io_regs.sv
// Functional notes
// - write-only clock modulator zero at 0x0A, resets to all zeros.
// - write-only clock modulator one at 0x0B, resets to all zeros.
// - write-only bank zero control at 0x14, resets with only bit 3 set.
// - write-only memory timing at 0x19, low nibble resets to zero.
// - read-only identity registers: processor at 0x2E, revision at 0x2F.
// - low five bits of each identity register hold a fixed chip code.
// - processor code same for all revisions; revision code distinct per revision.
// - bit 7 of identity registers reports whether boot-mode fetch is ignored.
// - bits 6 and 5 of identity registers report the sampled boot-mode pins.
// - character is start bit, data bits, flag or stop, then stop bit.
// - each port's marked byte register sends byte followed by two high bits.
// - write loads transmit buffer with byte plus a one marker bit after data.
// - read of marked byte register returns that port's receive buffer.
// - marked byte registers at 0xC2, 0xD2, 0xE2, 0xF2; undefined after reset.
`timescale 1ns/1ps
`default_nettype none
module revision_io_regs #(
    parameter int                        BIT_CYCLES = io_regs_pkg::BIT_CYCLES_DEFAULT,
    parameter logic [4:0]                CPU_CODE   = 5'h15, // arbitrary value
    parameter logic [4:0]                REV_CODE   = 5'h16  // arbitrary value
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [7:0]              io_addr,
    input  wire logic                    io_wr,
    input  wire logic                    io_rd,
    input  wire logic [7:0]              io_wdata,
    output logic      [7:0]              io_rdata,
    output logic                         io_rvalid,
    output logic      [3:0]              port_write_ready,
    input  wire logic [1:0]              boot_mode_pins,
    input  wire logic                    fetch_ignore_pin,
    input  wire logic [3:0][7:0]         rx_buffer,
    output logic      [3:0]              tx_line,
    output logic      [7:0]              clock_modulator_zero,
    output logic      [7:0]              clock_modulator_one,
    output logic      [7:0]              memory_bank_zero_control,
    output logic      [7:0]              memory_timing_control
);
    import io_regs_pkg::*;

    // frame timing and buffer limits
    localparam logic [15:0] BIT_LAST   = 16'(BIT_CYCLES - 1);
    localparam logic [3:0]  FRAME_LAST = 4'(FRAME_BITS - 1);
    localparam logic [3:0]  MARK_POS   = 4'(FRAME_BITS - 2);
    localparam logic [1:0]  BUF_FULL   = 2'(BUFFER_DEPTH);

    typedef struct packed {
        logic [7:0]                   clk_mod0;
        logic [7:0]                   clk_mod1;
        logic [7:0]                   bank0;
        logic [7:0]                   timing;
        logic [1:0]                   boot_meta;
        logic [1:0]                   boot_sync;
        logic                         fetch_meta;
        logic                         fetch_sync;
        logic [7:0]                   rdata;
        logic                         rvalid;
        logic [3:0][1:0][7:0]         buf_mem;
        logic [3:0]                   wptr;
        logic [3:0]                   rptr;
        logic [3:0][1:0]              count;
        tx_state_type [3:0]           state;
        logic [3:0][10:0]             shift;
        logic [3:0][3:0]              bits;
        logic [3:0][15:0]             baud;
        logic [3:0]                   tx;
    } state_type;

    state_type r_q;
    state_type r_d;

    logic [3:0][7:0] port_addr;
    logic [7:0]      id_upper;

    assign port_addr = {PORT_D_MARKED_ADDR, PORT_C_MARKED_ADDR,
                        PORT_B_MARKED_ADDR, PORT_A_MARKED_ADDR};
    assign id_upper  = {r_q.fetch_sync, r_q.boot_sync, 5'h00};

    always_comb begin
        logic       push;
        logic       pop;
        push  = 1'b0;
        pop   = 1'b0;
        r_d   = r_q;
        // pin synchronisers
        r_d.boot_meta  = boot_mode_pins;
        r_d.boot_sync  = r_q.boot_meta;
        r_d.fetch_meta = fetch_ignore_pin;
        r_d.fetch_sync = r_q.fetch_meta;
        // register writes
        if (io_wr) begin
            unique case (io_addr)
                CLOCK_MOD_ZERO_ADDR: begin
                    r_d.clk_mod0 = io_wdata;
                end
                CLOCK_MOD_ONE_ADDR: begin
                    r_d.clk_mod1 = io_wdata;
                end
                BANK_ZERO_CTRL_ADDR: begin
                    r_d.bank0 = io_wdata;
                end
                MEM_TIMING_ADDR: begin
                    r_d.timing = io_wdata;
                end
                default: begin
                    r_d.timing = r_q.timing; // identity writes ignored
                end
            endcase
        end
        // register reads
        r_d.rvalid = io_rd;
        r_d.rdata  = UNMAPPED_READ;
        if (io_rd) begin
            if (io_addr == PROC_IDENTITY_ADDR) begin
                r_d.rdata = id_upper | {3'h0, CPU_CODE};
            end else if (io_addr == REV_IDENTITY_ADDR) begin
                r_d.rdata = id_upper | {3'h0, REV_CODE};
            end
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (io_addr == port_addr[p]) begin
                    r_d.rdata = rx_buffer[p];
                end
            end
        end
        // per-port buffer and transmitter
        for (int p = 0; p < NUM_PORTS; p++) begin
            push = io_wr && (io_addr == port_addr[p]) && (r_q.count[p] != BUF_FULL);
            pop  = (r_q.state[p] == TX_IDLE) && (r_q.count[p] != 2'h0);
            if (push) begin
                r_d.buf_mem[p][r_q.wptr[p]] = io_wdata;
                r_d.wptr[p] = ~r_q.wptr[p];
            end
            if (push && !pop) begin
                r_d.count[p] = r_q.count[p] + 2'h1;
            end else if (pop && !push) begin
                r_d.count[p] = r_q.count[p] - 2'h1;
            end
            unique case (r_q.state[p])
                TX_IDLE: begin
                    r_d.tx[p] = STOP_BIT;
                    if (pop) begin
                        // start, data lsb first, marker, stop
                        r_d.shift[p] = {STOP_BIT, MARKER_BIT, r_q.buf_mem[p][r_q.rptr[p]],
                                        START_BIT};
                        r_d.rptr[p]  = ~r_q.rptr[p];
                        r_d.tx[p]    = START_BIT;
                        r_d.bits[p]  = 4'h0;
                        r_d.baud[p]  = 16'h0000;
                        r_d.state[p] = TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (r_q.baud[p] == BIT_LAST) begin
                        r_d.baud[p] = 16'h0000;
                        if (r_q.bits[p] == FRAME_LAST) begin
                            r_d.state[p] = TX_IDLE;
                            r_d.tx[p]    = STOP_BIT;
                        end else begin
                            r_d.bits[p]  = r_q.bits[p] + 4'h1;
                            r_d.shift[p] = {1'b1, r_q.shift[p][10:1]};
                            r_d.tx[p]    = r_q.shift[p][1];
                        end
                    end else begin
                        r_d.baud[p] = r_q.baud[p] + 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_q            <= '0;
            r_q.clk_mod0   <= CLOCK_MOD_RESET;
            r_q.clk_mod1   <= CLOCK_MOD_RESET;
            r_q.bank0      <= BANK_ZERO_RESET;
            r_q.timing     <= MEM_TIMING_RESET;
            r_q.tx         <= 4'hF;
        end else begin
            r_q <= r_d;
        end
    end

    assign io_rdata                 = r_q.rdata;
    assign io_rvalid                = r_q.rvalid;
    assign clock_modulator_zero     = r_q.clk_mod0;
    assign clock_modulator_one      = r_q.clk_mod1;
    assign memory_bank_zero_control = r_q.bank0;
    assign memory_timing_control    = r_q.timing;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_clock_mod_zero: assert property (
        io_wr && io_addr == CLOCK_MOD_ZERO_ADDR |=> clock_modulator_zero == $past(io_wdata))
        else $error("clock modulator zero not written");

    a_clock_mod_one: assert property (
        io_wr && io_addr == CLOCK_MOD_ONE_ADDR |=> clock_modulator_one == $past(io_wdata))
        else $error("clock modulator one not written");

    a_bank_zero_write: assert property (
        io_wr && io_addr == BANK_ZERO_CTRL_ADDR |=> memory_bank_zero_control == $past(io_wdata))
        else $error("bank zero control not written");

    a_timing_write: assert property (
        io_wr && io_addr == MEM_TIMING_ADDR |=> memory_timing_control == $past(io_wdata))
        else $error("memory timing not written");

    a_cpu_id_read: assert property (
        io_rd && io_addr == PROC_IDENTITY_ADDR |=> io_rvalid && io_rdata[4:0] == CPU_CODE)
        else $error("processor identity code wrong");

    a_rev_id_read: assert property (
        io_rd && io_addr == REV_IDENTITY_ADDR |=> io_rvalid && io_rdata[4:0] == REV_CODE)
        else $error("revision identity code wrong");

    a_fetch_bit: assert property (
        io_rd && (io_addr == PROC_IDENTITY_ADDR || io_addr == REV_IDENTITY_ADDR)
        |=> io_rdata[FETCH_IGNORE_BIT] == $past(r_q.fetch_sync))
        else $error("fetch ignore bit wrong");

    a_boot_bits: assert property (
        io_rd && (io_addr == PROC_IDENTITY_ADDR || io_addr == REV_IDENTITY_ADDR)
        |=> io_rdata[BOOT_MODE_HI_BIT:BOOT_MODE_LO_BIT] == $past(r_q.boot_sync))
        else $error("boot mode bits wrong");

    a_id_write_none: assert property (
        io_wr && (io_addr == PROC_IDENTITY_ADDR || io_addr == REV_IDENTITY_ADDR)
        |=> $stable(clock_modulator_zero) && $stable(clock_modulator_one)
            && $stable(memory_bank_zero_control) && $stable(memory_timing_control))
        else $error("identity write changed state");

    a_read_valid: assert property (
        io_rd |=> io_rvalid)
        else $error("read not answered");

    a_valid_only_read: assert property (
        !io_rd |=> !io_rvalid)
        else $error("read valid without read");

    a_rdata_idle: assert property (
        !io_rd |=> io_rdata == UNMAPPED_READ)
        else $error("read data not cleared");

    a_wo_read_zero: assert property (
        io_rd && (io_addr == CLOCK_MOD_ZERO_ADDR || io_addr == CLOCK_MOD_ONE_ADDR
        || io_addr == BANK_ZERO_CTRL_ADDR || io_addr == MEM_TIMING_ADDR) |=> io_rdata == UNMAPPED_READ)
        else $error("write-only register readable");

    a_mod_zero_hold: assert property (
        !(io_wr && io_addr == CLOCK_MOD_ZERO_ADDR) |=> $stable(clock_modulator_zero))
        else $error("clock modulator zero changed");

    a_mod_one_hold: assert property (
        !(io_wr && io_addr == CLOCK_MOD_ONE_ADDR) |=> $stable(clock_modulator_one))
        else $error("clock modulator one changed");

    a_bank_hold: assert property (
        !(io_wr && io_addr == BANK_ZERO_CTRL_ADDR) |=> $stable(memory_bank_zero_control))
        else $error("bank zero control changed");

    a_timing_hold: assert property (
        !(io_wr && io_addr == MEM_TIMING_ADDR) |=> $stable(memory_timing_control))
        else $error("memory timing changed");

    generate
        for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
            assign tx_line[g]          = r_q.tx[g];
            assign port_write_ready[g] = (r_q.count[g] != BUF_FULL);

            a_start_low: assert property (
                r_q.state[g] == TX_SHIFT && r_q.bits[g] == 4'h0 |-> tx_line[g] == START_BIT)
                else $error("start bit not low");

            a_marker_high: assert property (
                r_q.state[g] == TX_SHIFT && r_q.bits[g] == MARK_POS |-> tx_line[g] == MARKER_BIT)
                else $error("marker bit not high");

            a_stop_high: assert property (
                r_q.state[g] == TX_SHIFT && r_q.bits[g] == FRAME_LAST |-> tx_line[g] == STOP_BIT)
                else $error("stop bit not high");

            a_rx_read: assert property (
                io_rd && io_addr == port_addr[g] |=> io_rdata == $past(rx_buffer[g]))
                else $error("receive buffer read wrong");

            a_rx_valid: assert property (
                io_rd && io_addr == port_addr[g] |=> io_rvalid)
                else $error("receive buffer read not answered");

            a_port_push: assert property (
                io_wr && io_addr == port_addr[g] && port_write_ready[g] && r_q.state[g] == TX_SHIFT
                |=> r_q.count[g] == $past(r_q.count[g]) + 2'h1)
                else $error("marked byte not buffered");

            a_idle_line_high: assert property (
                r_q.state[g] == TX_IDLE |-> tx_line[g] == STOP_BIT)
                else $error("idle line not high");

            a_full_drop: assert property (
                io_wr && io_addr == port_addr[g] && !port_write_ready[g] && r_q.state[g] == TX_SHIFT
                |=> !port_write_ready[g])
                else $error("full buffer took a byte");

            a_count_bound: assert property (
                r_q.count[g] <= BUF_FULL)
                else $error("buffer count overflow");

            a_bit_hold: assert property (
                r_q.state[g] == TX_SHIFT && r_q.baud[g] != BIT_LAST |=> $stable(tx_line[g]))
                else $error("bit changed early");

            a_line_follows: assert property (
                r_q.state[g] == TX_SHIFT |-> tx_line[g] == r_q.shift[g][0])
                else $error("line differs from frame");

            a_pop_start: assert property (
                r_q.state[g] == TX_IDLE && r_q.count[g] != 2'h0
                |=> r_q.state[g] == TX_SHIFT && tx_line[g] == START_BIT)
                else $error("buffered byte not started");

            a_marked_count: assert property (
                r_q.state[g] == TX_IDLE && r_q.count[g] != 2'h0 && !(io_wr && io_addr == port_addr[g])
                |=> r_q.count[g] == $past(r_q.count[g]) - 2'h1)
                else $error("buffered byte not taken");

            a_baud_bound: assert property (
                r_q.baud[g] <= BIT_LAST)
                else $error("bit counter overrun");

            a_bits_bound: assert property (
                r_q.bits[g] <= FRAME_LAST)
                else $error("frame counter overrun");
        end
    endgenerate

    c_port_full: cover property (port_write_ready[0] == 1'b0);
    c_frame_done: cover property (r_q.state[0] == TX_SHIFT ##1 r_q.state[0] == TX_IDLE);
    c_id_read: cover property (io_rd && io_addr == REV_IDENTITY_ADDR);
    c_rx_read: cover property (io_rd && io_addr == PORT_D_MARKED_ADDR);
    c_full_drop: cover property (io_wr && io_addr == PORT_A_MARKED_ADDR && port_write_ready[0] == 1'b0);
endmodule
`default_nettype wire
